// ==== src/eelc_defines.svh ====
`ifndef EELC_DEFINES_SVH
`define EELC_DEFINES_SVH

// line counts
`define EELC_NUM_LINES      23
`define EELC_NUM_PIN_LINES  16
`define EELC_NUM_PINS       140
`define EELC_SEL_W          8

// register byte offsets
`define EELC_OFF_INTMASK    12'h000
`define EELC_OFF_EVTMASK    12'h004
`define EELC_OFF_RISE       12'h008
`define EELC_OFF_FALL       12'h00c
`define EELC_OFF_PENDING    12'h010
`define EELC_OFF_LEVEL      12'h014
`define EELC_OFF_PINSEL0    12'h018
`define EELC_PINSEL_WORDS   4

// reset values
`define EELC_RST_MASK       23'h000000
`define EELC_RST_EDGE       23'h000000
`define EELC_RST_PINSEL     8'h00

`endif

// ==== src/eelc_pkg.sv ====
package eelc_pkg;

  // trigger selection, bit 0 rising, bit 1 falling
  typedef enum logic [1:0] {
    TRIG_NONE = 2'b00,
    TRIG_RISE = 2'b01,
    TRIG_FALL = 2'b10,
    TRIG_BOTH = 2'b11
  } eelc_trig_e;

  typedef struct packed {
    eelc_trig_e trig;
    logic       intEn;
    logic       evtEn;
  } eelc_line_cfg_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } eelc_apb_req_s;

endpackage

// ==== src/eelc_line.sv ====
`timescale 1ns/1ps
`include "eelc_defines.svh"

module eelc_line (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  // line input and setup
  input  wire logic                    sample,
  input  wire eelc_pkg::eelc_line_cfg_s cfg,
  input  wire logic                    clearPend,
  // requests
  output logic                         pending,
  output logic                         evtPulse
);

  logic prev;
  logic hit;
  logic next_pending;

  wire riseSeen = sample & ~prev;
  wire fallSeen = ~sample & prev;

  // R02: edge choice
  always_comb begin
    case (cfg.trig)
      eelc_pkg::TRIG_NONE: hit = 1'b0;
      eelc_pkg::TRIG_RISE: hit = riseSeen;
      eelc_pkg::TRIG_FALL: hit = fallSeen;
      eelc_pkg::TRIG_BOTH: hit = riseSeen | fallSeen;
      default:             hit = 1'b0;
    endcase
  end

  // R03: mask gates request
  // R07: set beats clear
  assign next_pending = (hit & cfg.intEn) | (pending & ~clearPend);

  // R04: latch pending bit
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prev     <= 1'b0;
      pending  <= 1'b0;
      evtPulse <= 1'b0;
    end else begin
      prev     <= sample;
      pending  <= next_pending;
      evtPulse <= hit & cfg.evtEn;
    end
  end

endmodule // eelc_line

// ==== src/eelc_top.sv ====
// Contract
// R01: twenty-three independent edge lines raise requests
// R02: per-line rising, falling or both edges
// R03: per-line mask blocks that line only
// R04: detected requests latch readable pending bits
// R05: single-cycle input pulses are still caught
// R06: sixteen lines pick one of 140 pins
// R07: write one clears pending; a new edge sets it and beats the clear
`timescale 1ns/1ps
`include "eelc_defines.svh"

module eelc_top #(
  parameter int NUM_LINES     = `EELC_NUM_LINES,
  parameter int NUM_PIN_LINES = `EELC_NUM_PIN_LINES,
  parameter int NUM_PINS      = `EELC_NUM_PINS
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // event sources
  input  wire logic [NUM_PINS-1:0]           gpioPins,
  input  wire logic [NUM_LINES-NUM_PIN_LINES-1:0] internalEvents,
  // requests out
  output logic      [NUM_LINES-1:0]          lineIrq,
  output logic      [NUM_LINES-1:0]          lineEvent
);

  localparam int SW = `EELC_SEL_W;

  eelc_pkg::eelc_apb_req_s req;

  logic [NUM_LINES-1:0] intMask;
  logic [NUM_LINES-1:0] evtMask;
  logic [NUM_LINES-1:0] riseEn;
  logic [NUM_LINES-1:0] fallEn;
  logic [NUM_LINES-1:0] lineSample;
  logic [NUM_LINES-1:0] next_lineSample;
  logic [NUM_LINES-1:0] clearPend;
  logic [NUM_LINES-1:0] pendingBits;
  logic [NUM_LINES-1:0] evtBits;
  logic [SW-1:0]        pinSel [NUM_PIN_LINES];
  logic [31:0]          selWord [`EELC_PINSEL_WORDS];

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};

  // access decode; the answer takes one wait cycle so prdata is a flop
  wire accessPh  = req.psel & req.penable;
  wire firstAcc  = accessPh & ~pready;
  wire doneAcc   = accessPh & pready;
  wire wrEn      = doneAcc & req.pwrite;
  wire [11:0] wa = {req.paddr[11:2], 2'b00};

  wire selIntMask = (wa == `EELC_OFF_INTMASK);
  wire selEvtMask = (wa == `EELC_OFF_EVTMASK);
  wire selRise    = (wa == `EELC_OFF_RISE);
  wire selFall    = (wa == `EELC_OFF_FALL);
  wire selPending = (wa == `EELC_OFF_PENDING);
  wire selLevel   = (wa == `EELC_OFF_LEVEL);
  wire selPinSel  = (wa >= `EELC_OFF_PINSEL0) &&
                    (wa < `EELC_OFF_PINSEL0 + 12'(4 * `EELC_PINSEL_WORDS));
  wire [1:0] selIdx = 2'(( wa - `EELC_OFF_PINSEL0) >> 2);
  wire mapped = selIntMask | selEvtMask | selRise | selFall |
                selPending | selLevel | selPinSel;

  // write strobes, one per writable register, one shared by all pin select words
  wire wrIntMask = wrEn & selIntMask;
  wire wrEvtMask = wrEn & selEvtMask;
  wire wrRise    = wrEn & selRise;
  wire wrFall    = wrEn & selFall;
  wire wrPending = wrEn & selPending;
  wire wrPinSel  = wrEn & selPinSel;
  // bits above the last line are dropped on write
  wire [NUM_LINES-1:0] wrLines = pwdata[NUM_LINES-1:0];

  // pin selection words packed four lines to a word
  genvar w;
  generate
    for (w = 0; w < `EELC_PINSEL_WORDS; w++) begin : g_selword
      always_comb begin
        selWord[w] = 32'h00000000;
        for (int b = 0; b < 4; b++) begin
          if (w * 4 + b < NUM_PIN_LINES)
            selWord[w][b*SW +: SW] = pinSel[w*4+b];
        end
      end
    end
  endgenerate

  wire [31:0] rdWord =
      selIntMask ? 32'(intMask) :
      selEvtMask ? 32'(evtMask) :
      selRise    ? 32'(riseEn) :
      selFall    ? 32'(fallEn) :
      selPending ? 32'(pendingBits) :
      selLevel   ? 32'(lineSample) :
      selPinSel  ? selWord[selIdx] : 32'h00000000;

  // R07: write one clears
  assign clearPend = wrPending ? wrLines : '0;

  // zero outside the answer cycle keeps the read bus quiet
  wire [31:0] rdNext = (firstAcc & ~req.pwrite) ? rdWord : 32'h00000000;

  // one wait state: the answer follows the first access edge
  always_ff @(posedge mclk) begin
    if (!reset_n)
      pready <= 1'b0;
    else
      pready <= firstAcc;
  end

  // unmapped offsets answer with an error and drop writes
  always_ff @(posedge mclk) begin
    if (!reset_n)
      pslverr <= 1'b0;
    else
      pslverr <= firstAcc & ~mapped;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n)
      prdata <= 32'h00000000;
    else
      prdata <= rdNext;
  end

  // R03: interrupt mask register
  always_ff @(posedge mclk) begin
    if (!reset_n)
      intMask <= `EELC_RST_MASK;
    else if (wrIntMask)
      intMask <= wrLines;
  end

  // R03: event mask register
  always_ff @(posedge mclk) begin
    if (!reset_n)
      evtMask <= `EELC_RST_MASK;
    else if (wrEvtMask)
      evtMask <= wrLines;
  end

  // R02: rising edge enables
  always_ff @(posedge mclk) begin
    if (!reset_n)
      riseEn <= `EELC_RST_EDGE;
    else if (wrRise)
      riseEn <= wrLines;
  end

  // R02: falling edge enables
  always_ff @(posedge mclk) begin
    if (!reset_n)
      fallEn <= `EELC_RST_EDGE;
    else if (wrFall)
      fallEn <= wrLines;
  end

  // R06: pin selection writes
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PIN_LINES; i++)
        pinSel[i] <= `EELC_RST_PINSEL;
    end else if (wrPinSel) begin
      for (int i = 0; i < NUM_PIN_LINES; i++) begin
        if (selIdx == 2'(i / 4))
          pinSel[i] <= pwdata[(i % 4)*SW +: SW];
      end
    end
  end

  // R06: one pin per line
  // a select past the last pin reads as a quiet low
  always_comb begin
    next_lineSample = '0;
    for (int j = 0; j < NUM_PIN_LINES; j++) begin
      if (int'(pinSel[j]) < NUM_PINS)
        next_lineSample[j] = gpioPins[pinSel[j]];
    end
    next_lineSample[NUM_LINES-1:NUM_PIN_LINES] = internalEvents;
  end

  // R05: every cycle sampled
  // no filter or synchroniser stage, so a level held for a single cycle
  // still yields both of its edges; inputs must be clock-synchronous
  // changing a pin select may itself look like an edge: mask first
  always_ff @(posedge mclk) begin
    if (!reset_n)
      lineSample <= '0;
    else
      lineSample <= next_lineSample;
  end

  // R01: one detector per line
  genvar k;
  generate
    for (k = 0; k < NUM_LINES; k++) begin : g_line
      eelc_pkg::eelc_line_cfg_s cfg;
      assign cfg = '{trig:  eelc_pkg::eelc_trig_e'({fallEn[k], riseEn[k]}),
                     intEn: intMask[k],
                     evtEn: evtMask[k]};
      eelc_line u_line (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .sample    (lineSample[k]),
        .cfg       (cfg),
        .clearPend (clearPend[k]),
        .pending   (pendingBits[k]),
        .evtPulse  (evtBits[k])
      );
    end
  endgenerate

  // R04: pending drives request
  assign lineIrq   = pendingBits;
  assign lineEvent = evtBits;

endmodule // eelc_top

// ==== tb/eelc_src_model.sv ====
`timescale 1ns/1ps
module eelc_src_model (
  // clock
  input  wire logic         mclk,
  // line side
  input  wire logic [22:0]  lineEvent,
  output logic      [139:0] gpioPins,
  output logic      [6:0]   internalEvents
);
  logic [146:0] src = '0;
  int           evtSeen = 0;
  assign gpioPins = src[139:0];
  assign internalEvents = src[146:140];
  task automatic drive(input logic [146:0] v);
    src <= v;
  endtask
  always @(posedge mclk) if (|lineEvent) evtSeen++;
endmodule // eelc_src_model

// ==== tb/eelc_top_sva.sv ====
`timescale 1ns/1ps
module eelc_top_sva #(
  parameter int NUM_LINES     = 23,
  parameter int NUM_PIN_LINES = 16,
  parameter int NUM_PINS      = 140
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 reset_n,
  // apb
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // lines
  input wire logic [NUM_PINS-1:0]  gpioPins,
  input wire logic [NUM_LINES-NUM_PIN_LINES-1:0] internalEvents,
  input wire logic [NUM_LINES-1:0] lineIrq,
  input wire logic [NUM_LINES-1:0] lineEvent
);
  localparam int HI = NUM_LINES - 1;
  localparam int LO = NUM_PIN_LINES;
  wire logic pendWr = psel && penable && pready && pwrite
    && paddr[11:2] == 10'h004;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wait_state_a: assert property (
    psel && penable && !pready |=> pready) else $error("no answer");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("pready too long");
  bad_addr_a: assert property (
    pready |-> pslverr == (paddr[11:2] > 10'd9)) else $error("pslverr");
  idle_data_a: assert property (
    !pready |-> prdata == 32'h0) else $error("prdata idle");
  top_zero_a: assert property (
    pready && paddr[11:2] < 10'd6 |-> (prdata >> NUM_LINES) == 32'h0)
    else $error("high bits");
  irq_clear_a: assert property (
    $past(reset_n) && |($past(lineIrq) & ~lineIrq) |-> $past(pendWr))
    else $error("irq dropped alone");
  irq_cause_a: assert property (
    (lineIrq[HI:LO] & ~$past(lineIrq[HI:LO]) & ~($past(internalEvents, 2)
    ^ $past(internalEvents, 3))) == '0) else $error("irq no edge");
  evt_cause_a: assert property (
    (lineEvent[HI:LO] & ~($past(internalEvents, 2)
    ^ $past(internalEvents, 3))) == '0) else $error("event no edge");
  cover property (pready && pslverr);
  cover property (pendWr && |lineIrq);
  cover property (|lineEvent[HI:LO]);
endmodule // eelc_top_sva

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "eelc_defines.svh"
module tb;
  logic         mclk = 0;
  logic         reset_n = 0;
  logic         psel = 0;
  logic         penable = 0;
  logic         pwrite = 0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0;
  logic [31:0]  prdata;
  logic [31:0]  rd;
  logic         pready;
  logic         pslverr;
  logic         err;
  logic [139:0] gpioPins;
  logic [6:0]   internalEvents;
  logic [22:0]  lineIrq;
  logic [22:0]  lineEvent;
  int           err_total = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  always #20 mclk = ~mclk;
  eelc_top u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpioPins(gpioPins), .internalEvents(internalEvents),
    .lineIrq(lineIrq), .lineEvent(lineEvent));
  eelc_src_model u_src (.mclk(mclk), .lineEvent(lineEvent),
    .gpioPins(gpioPins), .internalEvents(internalEvents));
  task automatic conclude();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdChk(input logic [11:0] a, logic [31:0] e, string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  // a pulse lasts one clock; results appear two edges after the start and are read at the third
  task automatic fire(input logic [146:0] v, input logic pulse);
    u_src.drive(v);
    @(posedge mclk);
    if (pulse) u_src.drive(147'h0);
    repeat (2) @(posedge mclk);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rdChk(`EELC_OFF_RISE, 32'h0, "rise rst");
    rdChk(`EELC_OFF_PINSEL0, 32'h0, "sel rst");
    apb(1'b0, 12'h028, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    apb(1'b1, `EELC_OFF_INTMASK, 32'hff7bffff);
    rdChk(`EELC_OFF_INTMASK, 32'h007bffff, "mask");
    apb(1'b1, `EELC_OFF_EVTMASK, 32'h007fffff);
    apb(1'b1, `EELC_OFF_RISE, 32'h00060001);
    apb(1'b1, `EELC_OFF_FALL, 32'h00030000);
    apb(1'b1, `EELC_OFF_PINSEL0, 32'h00000089);
    rdChk(`EELC_OFF_PINSEL0, 32'h00000089, "sel rd");
    fire(147'h1 << 137, 1'b1);
    chk({9'h0, lineIrq}, 32'h1, "pin irq");
    chk({9'h0, lineEvent}, 32'h1, "pin evt");
    rdChk(`EELC_OFF_PENDING, 32'h1, "pend");
    apb(1'b1, `EELC_OFF_PENDING, 32'h1);
    chk({9'h0, lineIrq}, 32'h0, "cleared");
    fire(147'h7 << 140, 1'b0);
    chk({9'h0, lineIrq}, 32'h00020000, "rise irq");
    chk({9'h0, lineEvent}, 32'h00060000, "rise evt");
    rdChk(`EELC_OFF_LEVEL, 32'h00070000, "level");
    apb(1'b1, `EELC_OFF_PENDING, 32'hffffffff);
    fire(147'h0, 1'b0);
    chk({9'h0, lineIrq}, 32'h00030000, "fall irq");
    rdChk(`EELC_OFF_PENDING, 32'h00030000, "pend2");
    apb(1'b1, `EELC_OFF_EVTMASK, 32'h0);
    rdChk(`EELC_OFF_EVTMASK, 32'h0, "evt mask");
    fire(147'h1 << 137, 1'b1);
    chk({9'h0, lineEvent}, 32'h0, "evt masked");
    chk({9'h0, lineIrq}, 32'h00030001, "irq kept");
    chk(u_src.evtSeen, 32'd3, "evt count");
    conclude();
  end
endmodule // tb
bind eelc_top eelc_top_sva #(.NUM_LINES(NUM_LINES),
  .NUM_PIN_LINES(NUM_PIN_LINES), .NUM_PINS(NUM_PINS)) u_sva (
  .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .gpioPins(gpioPins),
  .internalEvents(internalEvents), .lineIrq(lineIrq),
  .lineEvent(lineEvent));
